// ===== gpp_defines.svh
/*
 * constants of the general purpose port: widths, pin positions, reset
 * values and remap masks.
 * assumes it is included by its bare name inside the port files.
 */
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH

// port width
`define GPP_NPINS 8
// pin that carries the clock output
`define GPP_CLKOUT_PIN 7
// pin that carries the event channel output
`define GPP_EVOUT_PIN 6
// reset values of the software registers
`define GPP_DIR_RST 8'h00
`define GPP_OUT_RST 8'h00
`define GPP_MASK_RST 8'h00
// pins used by each peripheral group at its default location
`define GPP_TC_PINS 8'h0F
`define GPP_USART_PINS 8'h0C
`define GPP_SPI_PINS 8'hF0
// remapped location is the default rotated by this many pins
`define GPP_REMAP_SHIFT 4

`endif

// ===== gpp_pkg.sv
/*
 * types of the general purpose port: pin configuration, software
 * access requests, alternate function carrier and state records.
 * assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package gpp_pkg;

  // output driver and pull choice of a pin
  typedef enum logic [2:0] {
    GPP_OPC_TOTEM, GPP_OPC_BUSKEEP, GPP_OPC_PULLDN, GPP_OPC_PULLUP,
    GPP_OPC_WOR, GPP_OPC_WAND, GPP_OPC_WOR_PD, GPP_OPC_WAND_PU
  } gpp_opc_type;

  // input sense condition of a pin
  typedef enum logic [1:0] {
    GPP_ISC_BOTH, GPP_ISC_RISE, GPP_ISC_FALL, GPP_ISC_LOW
  } gpp_isc_type;

  // per pin configuration record
  typedef struct packed {
    logic inv;
    logic slew;
    gpp_opc_type opc;
    gpp_isc_type isc;
  } gpp_pin_cfg_type;

  // register targeted by an access
  typedef enum logic [1:0] {
    GPP_TGT_DIR, GPP_TGT_OUT, GPP_TGT_MASK0, GPP_TGT_MASK1
  } gpp_target_type;

  // kind of update
  typedef enum logic [1:0] {
    GPP_OP_WRITE, GPP_OP_SET, GPP_OP_CLR, GPP_OP_TGL
  } gpp_op_type;

  // whole-register access through write/set/clear/toggle locations
  typedef struct packed {
    logic valid;
    gpp_target_type target;
    gpp_op_type op;
    logic [7:0] data;
  } gpp_access_type;

  // single bit access through the bit addressable space
  typedef struct packed {
    logic valid;
    gpp_target_type target;
    logic value;
    logic [2:0] idx;
  } gpp_bit_access_type;

  // alternate function request, one bit per pin
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] val;
  } gpp_alt_type;

  // state of one pin input cell
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic evt;
  } gpp_cell_state_type;

  // state of the whole port
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] out;
    logic [7:0] mask0;
    logic [7:0] mask1;
    gpp_pin_cfg_type [7:0] cfg;
    logic [7:0] keep;
    logic [1:0] intf;
    logic [7:0] drv;
    logic [7:0] oe_b;
    logic [7:0] pu;
    logic [7:0] pd;
  } gpp_state_type;

endpackage

`default_nettype wire

// ===== gpp_pin_cell.sv
/*
 * input cell of one port pin: inversion, two stage synchroniser,
 * edge or level detection and the clockless wake compare.
 * assumes the pin input is free running and may be asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none

module gpp_pin_cell
  import gpp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // pin and configuration
  input wire logic pin_i,
  input wire logic inv_i,
  input wire gpp_isc_type isc_i,
  input wire logic clk_en_i,
  // results
  output logic level_o,
  output logic evt_o,
  output logic wake_o
);

  gpp_cell_state_type st; // registered state
  gpp_cell_state_type next_st; // next state
  logic inv_pin; // pin after optional inversion

  // inversion sits in front of all sensing
  assign inv_pin = pin_i ^ inv_i;

  // next state
  always_comb
  begin
    next_st = st;
    next_st.s1 = inv_pin;
    next_st.s2 = st.s1;
    next_st.evt = 1'b0;
    // edges are only judged while the port clock is enabled
    if (clk_en_i)
    begin
      next_st.prev = st.s2;
      unique case (isc_i)
        GPP_ISC_BOTH: next_st.evt = st.s2 ^ st.prev;
        GPP_ISC_RISE: next_st.evt = st.s2 & ~st.prev;
        GPP_ISC_FALL: next_st.evt = ~st.s2 & st.prev;
        GPP_ISC_LOW: next_st.evt = ~st.s2;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign level_o = st.s2;
  assign evt_o = st.evt;
  // clockless path: compares the raw pin with the level held when the
  // clock stopped, so no edge is needed to see a change
  assign wake_o = ~clk_en_i & ((isc_i == GPP_ISC_LOW) ? ~inv_pin
                                                     : (inv_pin ^ st.prev));

endmodule

`default_nettype wire

// ===== gpp_port.sv
/*
 * eight pin general purpose port: direction, drive and pull per pin,
 * hardware bit update accesses, input sensing, two port interrupts,
 * clock and event outputs, alternate function takeover and remap.
 * assumes all control inputs are synchronous to clk_i and that the
 * pad outside resolves drive, enable and weak pulls into a wire.
 */
`timescale 1ns/100ps
`default_nettype none
`include "gpp_defines.svh"

// What this block does
// - eight pins, each configured on its own
// - per pin direction, eight output configurations, optional inversion
// - bus keeper weakly holds last driven level
// - sense both, rising, falling edge or low
// - clockless pin change raises a wake request
// - synchronous sensing only while port clock runs
// - inversion applied before input sensing
// - two interrupts, each with own pin mask
// - interrupt raised by masked pin sense event
// - set, clear, toggle change only addressed bits
// - direction change leaves other pins alone
// - one write configures several pins at once
// - pulls on inputs and wired configurations
// - peripheral or real time clock out on pin
// - event channel out on a pin
// - usart, spi, timer pins remappable
// - enabled peripheral takes over its pins
// - single bit access to port registers
// - per pin slew rate limitation
module gpp_port
  import gpp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // software accesses
  input wire gpp_access_type access_i,
  input wire gpp_bit_access_type bit_access_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_mask_i,
  input wire gpp_pin_cfg_type cfg_i,
  input wire logic [1:0] int_clr_i,
  input wire logic clk_en_i,
  // clock and event outputs
  input wire logic clkout_en_i,
  input wire logic clkout_rtc_i,
  input wire logic clkper_i,
  input wire logic rtc_clk_i,
  input wire logic evout_en_i,
  input wire logic [2:0] evout_sel_i,
  input wire logic [7:0] ev_chan_i,
  // peripheral alternate functions
  input wire gpp_alt_type tc_alt_i,
  input wire gpp_alt_type usart_alt_i,
  input wire gpp_alt_type spi_alt_i,
  input wire logic [2:0] remap_i,
  // pins
  input wire logic [7:0] port_pin_n_i,
  output logic [7:0] port_pin_n_o,
  output logic [7:0] port_pin_n_oe_b_o,
  output logic [7:0] pull_up_o,
  output logic [7:0] pull_dn_o,
  output logic [7:0] slew_limit_o,
  // state seen by software and the system
  output logic [7:0] dir_o,
  output logic [7:0] out_o,
  output logic [7:0] pin_level_o,
  output logic [7:0] sense_evt_o,
  output logic [1:0] int_o,
  output logic wake_o
);

  // ***********************************************************
  // state and helpers
  // ***********************************************************

  gpp_state_type st; // all registers of the port
  gpp_state_type next_st; // next value of them
  logic [7:0] inv_vec; // inversion bit of every pin
  logic [7:0] evt; // sense events from the cells
  logic [7:0] wake_vec; // clockless change per pin
  logic [7:0] alt_en; // pins taken by peripherals after remap
  logic [7:0] alt_val; // values those peripherals drive

  // one whole-register update; a write replaces, the others only
  // touch the bits written as one
  function automatic logic [7:0] apply_op(input logic [7:0] cur,
                                          input gpp_op_type op,
                                          input logic [7:0] data);
    logic [7:0] res;
    res = cur;
    unique case (op)
      GPP_OP_WRITE: res = data;
      GPP_OP_SET: res = cur | data;
      GPP_OP_CLR: res = cur & ~data;
      GPP_OP_TGL: res = cur ^ data;
    endcase
    return res;
  endfunction

  // applies both access kinds to one target register
  function automatic logic [7:0] update(input logic [7:0] cur,
                                        input gpp_target_type tgt,
                                        input gpp_access_type acc,
                                        input gpp_bit_access_type bacc);
    logic [7:0] res;
    logic [7:0] bit_mask;
    res = cur;
    bit_mask = 8'h01 << bacc.idx;
    if (acc.valid && acc.target == tgt)
      res = apply_op(res, acc.op, acc.data);
    // a single bit access is a set or clear of one lane, so it
    // cannot disturb the neighbours even on the same cycle
    if (bacc.valid && bacc.target == tgt)
      res = bacc.value ? (res | bit_mask) : (res & ~bit_mask);
    return res;
  endfunction

  // moves a group to its other location by rotating the pin index
  function automatic logic [7:0] rot(input logic [7:0] v,
                                     input logic on);
    return on ? {v[3:0], v[7:4]} : v;
  endfunction

  // configuration of every pin after a multi pin write
  function automatic gpp_pin_cfg_type [7:0] merge_cfg(
    input gpp_pin_cfg_type [7:0] cur,
    input logic [7:0] mask,
    input gpp_pin_cfg_type val);
    gpp_pin_cfg_type [7:0] res;
    res = cur;
    for (int i = 0; i < `GPP_NPINS; i++)
      if (mask[i])
        res[i] = val;
    return res;
  endfunction

  // ***********************************************************
  // input cells
  // ***********************************************************

  // one cell per pin; each carries its own synchroniser so sensing
  // never looks at a metastable first stage
  for (genvar g = 0; g < `GPP_NPINS; g++)
  begin : g_cell
    assign inv_vec[g] = st.cfg[g].inv;
    gpp_pin_cell u_cell (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(port_pin_n_i[g]),
      .inv_i(st.cfg[g].inv),
      .isc_i(st.cfg[g].isc),
      .clk_en_i(clk_en_i),
      .level_o(pin_level_o[g]),
      .evt_o(evt[g]),
      .wake_o(wake_vec[g])
    );
  end

  // ***********************************************************
  // alternate functions
  // ***********************************************************

  // later groups win where two enabled peripherals claim one pin;
  // a user must not enable overlapping functions deliberately
  always_comb
  begin
    alt_en = '0;
    alt_val = '0;
    for (int i = 0; i < `GPP_NPINS; i++)
    begin
      logic [7:0] tce;
      logic [7:0] tcv;
      logic [7:0] use_;
      logic [7:0] usv;
      logic [7:0] spe;
      logic [7:0] spv;
      tce = rot(tc_alt_i.en & `GPP_TC_PINS, remap_i[0]);
      tcv = rot(tc_alt_i.val, remap_i[0]);
      use_ = rot(usart_alt_i.en & `GPP_USART_PINS, remap_i[1]);
      usv = rot(usart_alt_i.val, remap_i[1]);
      spe = rot(spi_alt_i.en & `GPP_SPI_PINS, remap_i[2]);
      spv = rot(spi_alt_i.val, remap_i[2]);
      if (tce[i])
      begin
        alt_en[i] = 1'b1;
        alt_val[i] = tcv[i];
      end
      if (use_[i])
      begin
        alt_en[i] = 1'b1;
        alt_val[i] = usv[i];
      end
      if (spe[i])
      begin
        alt_en[i] = 1'b1;
        alt_val[i] = spv[i];
      end
    end
  end

  // ***********************************************************
  // next state
  // ***********************************************************

  always_comb
  begin
    next_st = st;
    // software registers; each bit stands alone
    next_st.dir = update(st.dir, GPP_TGT_DIR, access_i, bit_access_i);
    next_st.out = update(st.out, GPP_TGT_OUT, access_i, bit_access_i);
    next_st.mask0 = update(st.mask0, GPP_TGT_MASK0, access_i,
                           bit_access_i);
    next_st.mask1 = update(st.mask1, GPP_TGT_MASK1, access_i,
                           bit_access_i);
    // several pins take one configuration in one write
    if (cfg_wr_i)
      next_st.cfg = merge_cfg(st.cfg, cfg_mask_i, cfg_i);
    // interrupt flags: a new event beats a clear in the same cycle
    for (int k = 0; k < 2; k++)
    begin
      logic [7:0] m;
      m = (k == 0) ? st.mask0 : st.mask1;
      if (int_clr_i[k])
        next_st.intf[k] = 1'b0;
      if (|(evt & m))
        next_st.intf[k] = 1'b1;
    end
    // pin drivers, registered so the pad sees clean levels
    for (int i = 0; i < `GPP_NPINS; i++)
    begin
      logic src_en;
      logic val;
      logic v;
      logic drive;
      drive = 1'b0;
      src_en = st.dir[i] | alt_en[i];
      val = alt_en[i] ? alt_val[i] : st.out[i];
      if (i == `GPP_EVOUT_PIN && evout_en_i)
      begin
        src_en = 1'b1;
        val = ev_chan_i[evout_sel_i];
      end
      if (i == `GPP_CLKOUT_PIN && clkout_en_i)
      begin
        src_en = 1'b1;
        val = clkout_rtc_i ? rtc_clk_i : clkper_i;
      end
      v = val ^ st.cfg[i].inv;
      // wired modes drive only their dominant level
      unique case (st.cfg[i].opc)
        GPP_OPC_WOR, GPP_OPC_WOR_PD: drive = src_en & v;
        GPP_OPC_WAND, GPP_OPC_WAND_PU: drive = src_en & ~v;
        default: drive = src_en;
      endcase
      next_st.drv[i] = v;
      next_st.oe_b[i] = ~drive;
      // the keeper remembers the last level actually driven
      if (!st.oe_b[i])
        next_st.keep[i] = st.drv[i];
      next_st.pu[i] = 1'b0;
      next_st.pd[i] = 1'b0;
      unique case (st.cfg[i].opc)
        GPP_OPC_PULLUP: next_st.pu[i] = ~drive;
        GPP_OPC_PULLDN: next_st.pd[i] = ~drive;
        GPP_OPC_WAND_PU: next_st.pu[i] = 1'b1;
        GPP_OPC_WOR_PD: next_st.pd[i] = 1'b1;
        GPP_OPC_BUSKEEP:
        begin
          next_st.pu[i] = ~drive & next_st.keep[i];
          next_st.pd[i] = ~drive & ~next_st.keep[i];
        end
        default:
        begin
          next_st.pu[i] = 1'b0;
          next_st.pd[i] = 1'b0;
        end
      endcase
    end
  end

  // ***********************************************************
  // registers and outputs
  // ***********************************************************

  // state register; all pins float with no pulls after reset
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st <= '0;
      st.dir <= `GPP_DIR_RST;
      st.out <= `GPP_OUT_RST;
      st.mask0 <= `GPP_MASK_RST;
      st.mask1 <= `GPP_MASK_RST;
      st.oe_b <= 8'hFF;
    end
    else
      st <= next_st;
  end

  // slew limit is a plain per pin configuration bit
  always_comb
  begin
    for (int i = 0; i < `GPP_NPINS; i++)
      slew_limit_o[i] = st.cfg[i].slew;
  end

  assign port_pin_n_o = st.drv;
  assign port_pin_n_oe_b_o = st.oe_b;
  assign pull_up_o = st.pu;
  assign pull_dn_o = st.pd;
  assign dir_o = st.dir;
  assign out_o = st.out;
  assign sense_evt_o = evt;
  assign int_o = st.intf;
  // any masked pin may wake the device while the clock is off
  assign wake_o = |(wake_vec & (st.mask0 | st.mask1));

  // ***********************************************************
  // assertions
  // ***********************************************************

  a_set_dir_only: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    access_i.valid && access_i.target == GPP_TGT_DIR &&
    access_i.op == GPP_OP_SET && !bit_access_i.valid
    |=> st.dir == ($past(st.dir) | $past(access_i.data)))
    else $error("direction set touched other pins");

  a_toggle_out: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    access_i.valid && access_i.target == GPP_TGT_OUT &&
    access_i.op == GPP_OP_TGL && !bit_access_i.valid
    |=> st.out == ($past(st.out) ^ $past(access_i.data)))
    else $error("toggle of output register wrong");

  a_single_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bit_access_i.valid && bit_access_i.target == GPP_TGT_OUT
    |=> st.out[$past(bit_access_i.idx)] == $past(bit_access_i.value))
    else $error("single bit access lost");

  a_multi_cfg: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cfg_wr_i |=> st.cfg == merge_cfg($past(st.cfg), $past(cfg_mask_i),
                                     $past(cfg_i)))
    else $error("multi pin configuration wrong");

  a_int_raise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    |(evt & st.mask0) |=> int_o[0])
    else $error("port interrupt 0 not raised");

  a_sync_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clk_en_i ##1 !clk_en_i |-> evt == 8'h00)
    else $error("sensing active with clock off");

  a_wake_clockless: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wake_o |-> !clk_en_i)
    else $error("wake raised while clocked");

  a_keeper_pulls: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (pull_up_o & pull_dn_o) == 8'h00)
    else $error("pull up and down together");

  a_sync_depth: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !cfg_wr_i ##1 !cfg_wr_i ##1 !cfg_wr_i
    |-> pin_level_o == ($past(port_pin_n_i, 2) ^ inv_vec))
    else $error("pin level not two stages behind");

  a_input_float: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clkout_en_i && !evout_en_i
    |=> (port_pin_n_oe_b_o | $past(st.dir | alt_en)) == 8'hFF)
    else $error("input pin driven");

endmodule

`default_nettype wire

// ===== gpp_board_model.sv
/*
 * board side of the eight port pins: resolves drive, enable and weak
 * pulls of the port into a pin level, and lets the bench drive pins.
 * assumes one clock, the same as the port's, and no other board load.
 */
`timescale 1ns/100ps
`default_nettype none

module gpp_board_model
(
  // clock
  input wire logic clk_i,
  // port side of the pins
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_b_i,
  input wire logic [7:0] pu_i,
  input wire logic [7:0] pd_i,
  // external drivers on the board
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  // resolved pin levels
  output logic [7:0] pin_o
);
  // last resolved level, so that a floating pin never repeats it
  // starts known so that a pin floating from time zero never shows x
  logic [7:0] last = 8'h00;

  // ****************************************
  // pin resolution
  // ****************************************
  always @(posedge clk_i)
  begin
    last <= pin_o;
  end

  // strong drivers beat weak pulls; a floating pin shows junk
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (ext_en_i[i])
        pin_o[i] = ext_val_i[i];
      else if (!oe_b_i[i])
        pin_o[i] = drv_i[i];
      else if (pu_i[i])
        pin_o[i] = 1'b1;
      else if (pd_i[i])
        pin_o[i] = 1'b0;
      else
        pin_o[i] = ~last[i];
    end
  end
endmodule

`default_nettype wire

// ===== test_general_purpose_io_port.sv
/*
 * self-checking bench of the eight pin port: register updates, drive,
 * pulls, sensing, interrupts, wake, clock and event out, takeover.
 * assumes the port and board model files are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

module test_general_purpose_io_port
  import gpp_pkg::*;
;
  // clock, reset and every port input
  logic clk = 0, rst_b = 0, cfg_wr = 0, clk_en = 1, ck_en = 0, ck_rtc = 0;
  logic clkper = 0, rtc = 0, ev_en = 0;
  logic [1:0] iclr = 0;
  logic [2:0] ev_sel = 0, remap = 0;
  logic [7:0] cmask = 0, ev_ch = 0, ext_en = 0, ext_val = 0, pin;
  gpp_access_type acc_r = '0;
  gpp_bit_access_type bacc_r = '0;
  gpp_pin_cfg_type cfg_r = '0;
  gpp_alt_type tc_a = '0, us_a = '0, spi_a = '0;
  // port outputs
  logic [7:0] drv, oe_b, pu, pd, slew, dir, out, lvl, evt;
  logic [1:0] irq;
  logic wake;
  int miscompares = 0, checked = 0, cnt;

  always #12.5 clk = ~clk;

  gpp_port dut_u (.clk_i(clk), .rst_b_i(rst_b), .access_i(acc_r),
    .bit_access_i(bacc_r), .cfg_wr_i(cfg_wr), .cfg_mask_i(cmask),
    .cfg_i(cfg_r), .int_clr_i(iclr), .clk_en_i(clk_en),
    .clkout_en_i(ck_en), .clkout_rtc_i(ck_rtc), .clkper_i(clkper),
    .rtc_clk_i(rtc), .evout_en_i(ev_en), .evout_sel_i(ev_sel),
    .ev_chan_i(ev_ch), .tc_alt_i(tc_a), .usart_alt_i(us_a),
    .spi_alt_i(spi_a), .remap_i(remap), .port_pin_n_i(pin),
    .port_pin_n_o(drv), .port_pin_n_oe_b_o(oe_b), .pull_up_o(pu),
    .pull_dn_o(pd), .slew_limit_o(slew), .dir_o(dir), .out_o(out),
    .pin_level_o(lvl), .sense_evt_o(evt), .int_o(irq), .wake_o(wake));

  gpp_board_model board_u (.clk_i(clk), .drv_i(drv), .oe_b_i(oe_b),
    .pu_i(pu), .pd_i(pd), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .pin_o(pin));

  // ****************************************
  // access tasks
  // ****************************************
  // inputs move a fixed 2 ns after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one-cycle whole register update, result visible after it; the
  // idle cycle keeps two calls from touching acc_r in one step
  task automatic acc(input gpp_target_type t, input gpp_op_type o,
                     input logic [7:0] d);
    acc_r = {1'b1, t, o, d};
    tick(1);
    acc_r = '0;
    tick(1);
  endtask

  // configure every pin in m; drivers settle two edges later
  task automatic cfgw(input logic [7:0] m, input logic inv,
                      input logic sl, input gpp_opc_type o,
                      input gpp_isc_type s);
    cfg_wr = 1'b1;
    cmask = m;
    cfg_r = {inv, sl, o, s};
    tick(1);
    cfg_wr = 1'b0;
    tick(2);
  endtask

  task automatic print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // a hang costs far more than the few hundred cycles the tests need
  initial
  begin
    #(25 * 5000);
    miscompares++;
    print_verdict;
  end

  // ****************************************
  // tests
  // ****************************************
  logic [7:0] ops [4] = '{8'h0F, 8'h30, 8'h01, 8'hFF};
  logic [7:0] res [4] = '{8'h0F, 8'h3F, 8'h3E, 8'hC1};
  int evx [4] = '{2, 1, 1, 10};

  initial
  begin
    tick(4);
    rst_b = 1'b1;
    chk(dir, 8'h00, "dir reset");
    chk(oe_b, 8'hFF, "oe reset");
    chk({6'h0, irq}, 8'h00, "irq reset");
    // write, set, clear, toggle on direction and output
    for (int i = 0; i < 4; i++)
    begin
      acc(GPP_TGT_DIR, gpp_op_type'(i), ops[i]);
      chk(dir, res[i], "dir op");
      acc(GPP_TGT_OUT, gpp_op_type'(i), ops[i]);
      chk(out, res[i], "out op");
    end
    // single bit set on direction, then single bit clear on output
    bacc_r = {1'b1, GPP_TGT_DIR, 1'b1, 3'd1};
    tick(1);
    bacc_r = {1'b1, GPP_TGT_OUT, 1'b0, 3'd0};
    tick(1);
    bacc_r.valid = 1'b0;
    chk(dir, 8'hC3, "bit set");
    chk(out, 8'hC0, "bit clear");
    $display("register update test done");
    // totem drive, read back, then inversion on four pins at once
    acc(GPP_TGT_DIR, GPP_OP_WRITE, 8'hFF);
    acc(GPP_TGT_OUT, GPP_OP_WRITE, 8'hA5);
    tick(3);
    chk(drv, 8'hA5, "drive");
    chk(oe_b, 8'h00, "enable");
    chk(lvl, 8'hA5, "level");
    cfgw(8'h0F, 1'b1, 1'b0, GPP_OPC_TOTEM, GPP_ISC_BOTH);
    tick(2);
    chk(drv, 8'hAA, "inv drive");
    chk(lvl, 8'hA5, "inv level");
    cfgw(8'hFF, 1'b0, 1'b0, GPP_OPC_TOTEM, GPP_ISC_BOTH);
    $display("drive test done");
    // pulls, slew limit, wired drivers, keeper
    acc(GPP_TGT_DIR, GPP_OP_WRITE, 8'h00);
    cfgw(8'h02, 1'b0, 1'b1, GPP_OPC_PULLUP, GPP_ISC_BOTH);
    chk(pu, 8'h02, "pull up");
    chk(slew, 8'h02, "slew");
    cfgw(8'h02, 1'b0, 1'b0, GPP_OPC_PULLDN, GPP_ISC_BOTH);
    chk(pd, 8'h02, "pull down");
    acc(GPP_TGT_DIR, GPP_OP_WRITE, 8'hFF);
    acc(GPP_TGT_OUT, GPP_OP_WRITE, 8'h00);
    cfgw(8'h02, 1'b0, 1'b0, GPP_OPC_WOR, GPP_ISC_BOTH);
    chk(oe_b, 8'h02, "wor low");
    acc(GPP_TGT_OUT, GPP_OP_SET, 8'h02);
    tick(2);
    chk(oe_b, 8'h00, "wor high");
    cfgw(8'h02, 1'b0, 1'b0, GPP_OPC_WAND_PU, GPP_ISC_BOTH);
    chk(oe_b, 8'h02, "wand high");
    chk(pu, 8'h02, "wand pull");
    cfgw(8'h02, 1'b0, 1'b0, GPP_OPC_BUSKEEP, GPP_ISC_BOTH);
    acc(GPP_TGT_DIR, GPP_OP_CLR, 8'h02);
    tick(3);
    chk(pu, 8'h02, "keep one");
    acc(GPP_TGT_OUT, GPP_OP_CLR, 8'h02);
    acc(GPP_TGT_DIR, GPP_OP_SET, 8'h02);
    tick(3);
    acc(GPP_TGT_DIR, GPP_OP_CLR, 8'h02);
    tick(3);
    chk(pd, 8'h02, "keep zero");
    cfgw(8'hFF, 1'b0, 1'b0, GPP_OPC_TOTEM, GPP_ISC_BOTH);
    $display("driver test done");
    // every sense mode on pin 0, interrupt 0 sourced by pin 0
    acc(GPP_TGT_DIR, GPP_OP_WRITE, 8'h00);
    acc(GPP_TGT_MASK0, GPP_OP_WRITE, 8'h01);
    ext_en = 8'hFF;
    for (int i = 0; i < 4; i++)
    begin
      ext_val[0] = 1'b1;
      cfgw(8'h01, 1'b0, 1'b0, GPP_OPC_TOTEM, gpp_isc_type'(i));
      tick(6);
      cnt = 0;
      ext_val[0] = 1'b0;
      repeat (10)
      begin
        tick(1);
        cnt += evt[0];
      end
      ext_val[0] = 1'b1;
      repeat (10)
      begin
        tick(1);
        cnt += evt[0];
      end
      chk(8'(cnt), 8'(evx[i]), "sense count");
    end
    chk({6'h0, irq}, 8'h01, "irq0");
    iclr = 2'b11;
    tick(1);
    iclr = 2'b00;
    tick(1);
    chk({6'h0, irq}, 8'h00, "irq clear");
    acc(GPP_TGT_MASK0, GPP_OP_WRITE, 8'h00);
    acc(GPP_TGT_MASK1, GPP_OP_WRITE, 8'h01);
    cfgw(8'h01, 1'b0, 1'b0, GPP_OPC_TOTEM, GPP_ISC_FALL);
    ext_val[0] = 1'b0;
    tick(6);
    chk({6'h0, irq}, 8'h02, "irq1");
    $display("sense test done");
    // stopped clock: wake without sense events
    ext_val[0] = 1'b1;
    cfgw(8'h01, 1'b0, 1'b0, GPP_OPC_TOTEM, GPP_ISC_BOTH);
    tick(6);
    clk_en = 1'b0;
    tick(2);
    chk({7'h0, wake}, 8'h00, "wake idle");
    ext_val[0] = 1'b0;
    #1;
    chk({7'h0, wake}, 8'h01, "wake");
    tick(4);
    chk(evt, 8'h00, "no sync evt");
    clk_en = 1'b1;
    ext_en = 8'h00;
    $display("wake test done");
    // clock out, event out, alternate takeover and remap
    acc(GPP_TGT_DIR, GPP_OP_WRITE, 8'hFF);
    acc(GPP_TGT_OUT, GPP_OP_WRITE, 8'h00);
    ck_en = 1'b1;
    clkper = 1'b1;
    tick(3);
    chk(drv, 8'h80, "clk out");
    ck_rtc = 1'b1;
    tick(3);
    chk(drv, 8'h00, "rtc out");
    ck_en = 1'b0;
    ev_en = 1'b1;
    ev_sel = 3'd3;
    ev_ch = 8'h08;
    tick(3);
    chk(drv, 8'h40, "event out");
    ev_en = 1'b0;
    spi_a = {8'h10, 8'h10};
    tick(3);
    chk(drv, 8'h10, "alt");
    remap = 3'd4;
    tick(3);
    chk(drv, 8'h01, "remap");
    $display("output select test done");
    print_verdict;
  end
endmodule

`default_nettype wire
